// [inc/ppi_defines.svh]
// Constants for the program and priority interrupt block
`ifndef PPI_DEFINES_SVH
`define PPI_DEFINES_SVH
// Fixed single-level locations
`define PPI_SAVE_ADDR 12'h000
`define PPI_ENTRY_BASIC 12'h001
`define PPI_ENTRY_ALT 12'h021
// Priority unit figures
`define PPI_NUM_LEVELS 15
`define PPI_NUM_EXT 6
`define PPI_PUSH_WORDS 5
`define PPI_IDLE_LEVEL 4'hF
// Link timing: 5 MHz timing generator derived from 200 MHz
`define PPI_CLK_MHZ 200
`define PPI_TGEN_MHZ 5
`define PPI_TGEN_DIV (`PPI_CLK_MHZ / `PPI_TGEN_MHZ)
`endif

// [inc/ppi_pkg.sv]
// Types shared by the program and priority interrupt block
package ppi_pkg;
  typedef enum logic [2:0] {
    PPI_IDLE = 3'b000,
    PPI_SGL = 3'b001,
    PPI_PUSH = 3'b010,
    PPI_POP = 3'b011,
    PPI_FIRST = 3'b100
  } ppi_state_e;
  typedef logic [11:0] ppi_word_t;
  typedef logic [3:0] ppi_level_t;
endpackage

// [inc/ppi_arb_if.sv]
// Carrier between the priority encoder and the controller
`timescale 1ns/1ps
interface ppi_arb_if;
  logic [14:0] level_req;
  logic found;
  logic [3:0] best;
  modport enc (input level_req, output found, output best);
  modport ctl (output level_req, input found, input best);
endinterface

// [design/ppi_prio_enc.sv]
// Priority encoder: lowest level number wins
`timescale 1ns/1ps
module ppi_prio_enc
  import ppi_pkg::*;
(
  ppi_arb_if.enc arb
);
  // Scan from the lowest rank upward so level 0 wins last
  always_comb begin
    arb.found = 1'b0;
    arb.best = 4'h0;
    for (int i = 14; i >= 0; i--) begin
      if (arb.level_req[i]) begin
        arb.found = 1'b1;
        arb.best = 4'(i);
      end
    end
  end
endmodule

// [design/ppi_sync.sv]
// Two-stage synchroniser for request pins
`timescale 1ns/1ps
module ppi_sync #(
  parameter int W = 7
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_ff;
  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= '0;
      q_o <= '0;
    end else begin
      s1_ff <= d_i;
      q_o <= s1_ff;
    end
  end
endmodule

// [design/ppi_ctrl.sv]
// Program interrupt and priority interrupt controller
// Contract
// - Request line is the OR of all peripheral requests.
// - Interrupts taken only while enabled; interrupt-on instruction re-enables.
// - Basic-mode interrupt writes return count into location 0000.
// - Resume at 0001 in basic mode, 0041 in alternate mode.
// - Priority unit serves 15 levels, each with two-word vector.
// - Inputs come from one prewired option and up to six devices.
// - Levels are static jumpers; level 0 ranks highest.
// - No preemption until the routine's first instruction completes.
// - Priority unit disabled means ordinary single-level interrupt cycle.
// - Unit picks highest requesting level and vectors to its routine.
// - Push saves and pop restores the full register and status set.
// - Saved words go to a memory stack allowing nested levels.
// - Each push and pop takes exactly five break cycles in break state.
// - Unit has lowest break priority; other breaks granted during sequences.
// - Unit runs from its own 5 MHz timing, synchronised to the processor.
// - Push only when requested level ranks above current machine level.
// - Push writes five consecutive words at stack pointer, incrementing across fields.
// - Vector address bits 7..10 come from the level, giving even addresses.
// - Processor ends every push in basic instruction-set mode.
`timescale 1ns/1ps
`include "ppi_defines.svh"
module ppi_ctrl
  import ppi_pkg::*;
#(
  parameter int NUM_EXT = `PPI_NUM_EXT,
  parameter int TGEN_DIV = `PPI_TGEN_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Shared request line, active low, open collector
  input wire logic int_req_n_i,
  // Priority level request pins: bit 0 prewired option, then devices
  input wire logic [NUM_EXT:0] lvl_req_i,
  // Static jumper level per input
  input wire logic [4*(NUM_EXT+1)-1:0] lvl_jumper_i,
  input wire logic priority_unit_enable_i,
  input wire logic interrupt_on_instruction_i,
  input wire logic interrupt_off_i,
  input wire logic restore_i,
  input wire logic instr_done_i,
  input wire logic alt_mode_i,
  // Processor state presented for a push
  input wire logic [11:0] accumulator_i,
  input wire logic [11:0] program_counter_i,
  input wire logic [11:0] multiplier_quotient_i,
  input wire logic [2:0] instr_field_i,
  input wire logic [2:0] data_field_i,
  input wire logic link_i,
  input wire logic overflow_i,
  input wire logic user_flag_i,
  input wire logic [2:0] vec_field_i,
  input wire logic [6:0] vec_high_i,
  input wire logic [14:0] stack_base_i,
  input wire logic stack_load_i,
  // Break bus
  input wire logic other_brk_i,
  input wire logic brk_grant_i,
  input wire logic [11:0] mem_rdata_i,
  output logic brk_req_o,
  output logic break_state_o,
  output logic mem_we_o,
  output logic mem_re_o,
  output logic [14:0] mem_addr_o,
  output logic [11:0] mem_wdata_o,
  output logic pc_load_o,
  output logic [11:0] pc_value_o,
  output logic [2:0] if_value_o,
  output logic basic_mode_o,
  output logic restore_load_o,
  output logic [11:0] rest_ac_o,
  output logic [11:0] rest_mq_o,
  output logic [11:0] rest_status_o,
  output logic [11:0] rest_fields_o,
  output logic int_enable_o,
  output logic [3:0] machine_level_o
);
  // ****************************************************************
  // Checks and timing
  // ****************************************************************
  // Read slot tracking relies on two granted breaks never being adjacent
  if (NUM_EXT < 1 || NUM_EXT > 6) begin : g_bad_ext
    $error("NUM_EXT must be 1..6");
  end
  if (TGEN_DIV < 2 || TGEN_DIV > 256) begin : g_bad_div
    $error("TGEN_DIV must be 2..256");
  end

  ppi_state_e state_ff;
  ppi_state_e nxt_state;
  logic int_en_ff;
  logic [3:0] level_ff;
  logic [2:0] step_ff;
  logic [14:0] sp_ff;
  logic [7:0] div_ff;
  logic tick_ff;
  logic first_ff;
  logic alt_save_ff;
  logic [NUM_EXT:0] lvl_sync;
  logic req_sync;
  logic [11:0] frame [0:4];
  logic rd_vld_ff;
  logic [2:0] rd_slot_ff;
  logic [11:0] rest_pc_ff;
  ppi_arb_if arb ();

  // Pin inputs cross through two flops before any use
  ppi_sync #(.W(NUM_EXT + 2)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({~int_req_n_i, lvl_req_i}),
    .q_o({req_sync, lvl_sync})
  );

  ppi_prio_enc u_enc (
    .arb(arb)
  );

  // Map each input to its jumpered level
  always_comb begin
    arb.level_req = 15'h0000;
    for (int i = 0; i <= NUM_EXT; i++) begin
      if (lvl_sync[i] && lvl_jumper_i[4*i +: 4] != `PPI_IDLE_LEVEL)
        arb.level_req[lvl_jumper_i[4*i +: 4]] = 1'b1;
    end
  end

  // Own timing generator: sequencer only steps on its 5 MHz tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff <= 8'h00;
      tick_ff <= 1'b0;
    end else if (div_ff == 8'(TGEN_DIV - 1)) begin
      div_ff <= 8'h00;
      tick_ff <= 1'b1;
    end else begin
      div_ff <= div_ff + 8'h01;
      tick_ff <= 1'b0;
    end
  end

  // Stacked frame, in slot order P..P+4
  always_comb begin
    frame[0] = accumulator_i;
    frame[1] = program_counter_i;
    frame[2] = {alt_save_ff, overflow_i, link_i, 5'h00, level_ff};
    frame[3] = multiplier_quotient_i;
    frame[4] = {1'b0, user_flag_i, 2'b00, instr_field_i, 2'b00, data_field_i};
  end

  // Decide what to start at an instruction boundary
  wire take_single = req_sync && int_en_ff && !priority_unit_enable_i;
  wire take_push = arb.found && int_en_ff && priority_unit_enable_i && !first_ff
                   && (arb.best < level_ff);
  wire brk_ok = brk_grant_i && !other_brk_i && tick_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      PPI_IDLE: begin
        if (instr_done_i) begin
          if (take_push) nxt_state = PPI_PUSH;
          else if (take_single) nxt_state = PPI_SGL;
          else if (restore_i && priority_unit_enable_i) nxt_state = PPI_POP;
        end
      end
      PPI_SGL: nxt_state = PPI_IDLE;
      PPI_PUSH: if (brk_ok && step_ff == 3'd4) nxt_state = PPI_FIRST;
      PPI_POP: if (brk_ok && step_ff == 3'd4) nxt_state = PPI_IDLE;
      PPI_FIRST: if (instr_done_i) nxt_state = PPI_IDLE;
      default: nxt_state = PPI_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) state_ff <= PPI_IDLE;
    else state_ff <= nxt_state;
  end

  // ****************************************************************
  // Enable, level and stack pointer
  // ****************************************************************
  // Enable: set by interrupt-on, cleared on single-level acceptance or by interrupt-off
  always_ff @(posedge clk_i) begin
    if (rst_i) int_en_ff <= 1'b0;
    else if (state_ff == PPI_IDLE && nxt_state == PPI_SGL) int_en_ff <= 1'b0;
    else if (interrupt_on_instruction_i) int_en_ff <= 1'b1;
    else if (interrupt_off_i) int_en_ff <= 1'b0;
  end

  // Preemption held off until first routine instruction retires
  always_ff @(posedge clk_i) begin
    if (rst_i) first_ff <= 1'b0;
    else first_ff <= (nxt_state == PPI_FIRST);
  end

  // Step counter for the five break cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) step_ff <= 3'd0;
    else if (state_ff == PPI_IDLE) step_ff <= 3'd0;
    else if ((state_ff == PPI_PUSH || state_ff == PPI_POP) && brk_ok)
      step_ff <= (step_ff == 3'd4) ? 3'd0 : step_ff + 3'd1;
  end

  // Stack pointer: full 15-bit count so fields are crossed freely
  always_ff @(posedge clk_i) begin
    if (rst_i) sp_ff <= 15'h0000;
    else if (stack_load_i && state_ff == PPI_IDLE) sp_ff <= stack_base_i;
    else if (state_ff == PPI_PUSH && brk_ok) sp_ff <= sp_ff + 15'h0001;
    else if (state_ff == PPI_POP && brk_ok) sp_ff <= sp_ff - 15'h0001;
  end

  // Machine level and saved mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_ff <= `PPI_IDLE_LEVEL;
      alt_save_ff <= 1'b0;
    end else if (state_ff == PPI_IDLE && nxt_state == PPI_PUSH) begin
      alt_save_ff <= alt_mode_i;
    end else if (state_ff == PPI_PUSH && brk_ok && step_ff == 3'd4) begin
      level_ff <= arb.best;
    end else if (rd_vld_ff && rd_slot_ff == 3'd2) begin
      level_ff <= mem_rdata_i[3:0];
    end
  end

  // ****************************************************************
  // Memory and processor side outputs
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_we_o <= 1'b0;
      mem_re_o <= 1'b0;
      mem_addr_o <= 15'h0000;
      mem_wdata_o <= 12'h000;
      pc_load_o <= 1'b0;
      pc_value_o <= 12'h000;
      if_value_o <= 3'd0;
      basic_mode_o <= 1'b1;
      restore_load_o <= 1'b0;
    end else begin
      mem_we_o <= 1'b0;
      mem_re_o <= 1'b0;
      pc_load_o <= 1'b0;
      restore_load_o <= 1'b0;
      if (state_ff == PPI_SGL) begin
        // Single-level: save count in 0000 in basic mode only, jump to entry
        mem_we_o <= !alt_mode_i;
        mem_addr_o <= {3'd0, `PPI_SAVE_ADDR};
        mem_wdata_o <= program_counter_i;
        pc_load_o <= 1'b1;
        pc_value_o <= alt_mode_i ? `PPI_ENTRY_ALT : `PPI_ENTRY_BASIC;
        if_value_o <= 3'd0;
      end else if (state_ff == PPI_PUSH && brk_ok) begin
        mem_we_o <= 1'b1;
        mem_addr_o <= sp_ff;
        mem_wdata_o <= frame[step_ff];
        if (step_ff == 3'd4) begin
          pc_load_o <= 1'b1;
          pc_value_o <= {vec_high_i, arb.best, 1'b0};
          if_value_o <= vec_field_i;
          basic_mode_o <= 1'b1;
        end
      end else if (state_ff == PPI_POP && brk_ok) begin
        mem_re_o <= 1'b1;
        mem_addr_o <= sp_ff - 15'h0001;
      end
      // Last word back: hand over PC, field and mode together with the frame
      if (rd_vld_ff && rd_slot_ff == 3'd4) begin
        restore_load_o <= 1'b1;
        pc_load_o <= 1'b1;
        pc_value_o <= rest_pc_ff;
        if_value_o <= rest_fields_o[6:4];
        basic_mode_o <= !rest_status_o[11];
      end
    end
  end

  // Read data stands only in the cycle after the strobe, so track which slot it is
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_vld_ff <= 1'b0;
      rd_slot_ff <= 3'd0;
    end else begin
      rd_vld_ff <= mem_re_o;
      if (state_ff == PPI_POP && brk_ok) rd_slot_ff <= step_ff;
    end
  end

  // Popped words arrive last-in first: fields, MQ, status, PC, AC
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rest_ac_o <= 12'h000;
      rest_mq_o <= 12'h000;
      rest_status_o <= 12'h000;
      rest_fields_o <= 12'h000;
      rest_pc_ff <= 12'h000;
    end else if (rd_vld_ff) begin
      unique case (rd_slot_ff)
        3'd0: rest_fields_o <= mem_rdata_i;
        3'd1: rest_mq_o <= mem_rdata_i;
        3'd2: rest_status_o <= mem_rdata_i;
        3'd3: rest_pc_ff <= mem_rdata_i;
        3'd4: rest_ac_o <= mem_rdata_i;
        default: rest_ac_o <= rest_ac_o;
      endcase
    end
  end

  // Break request lowest priority: withdrawn while others request
  assign brk_req_o = (state_ff == PPI_PUSH || state_ff == PPI_POP) && !other_brk_i;
  assign break_state_o = (state_ff == PPI_PUSH || state_ff == PPI_POP);
  assign int_enable_o = int_en_ff;
  assign machine_level_o = level_ff;
endmodule

// [test/ppi_ctrl_properties.sv]
// Port checker for the interrupt controller
`timescale 1ns/1ps
module ppi_ctrl_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic priority_unit_enable_i,
  input wire logic other_brk_i,
  input wire logic brk_req_o,
  input wire logic break_state_o,
  input wire logic mem_we_o,
  input wire logic [14:0] mem_addr_o,
  input wire logic pc_load_o,
  input wire logic [11:0] pc_value_o,
  input wire logic basic_mode_o,
  input wire logic restore_load_o,
  input wire logic int_enable_o,
  input wire logic [3:0] machine_level_o
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  rst_idle_a: assert property ($past(rst_i) |-> machine_level_o == 4'hF && !int_enable_o)
    else $error("state after reset wrong");
  brk_yield_a: assert property (other_brk_i |-> !brk_req_o)
    else $error("break request while another device requests");
  brk_state_a: assert property (brk_req_o |-> break_state_o)
    else $error("break request outside break state");
  brk_span_a: assert property ($rose(break_state_o) |-> break_state_o [*8])
    else $error("break state too short for five cycles");
  sgl_entry_a: assert property (pc_load_o && !priority_unit_enable_i |->
    pc_value_o == 12'h001 || pc_value_o == 12'h021)
    else $error("single level entry address wrong");
  sgl_clear_a: assert property (pc_load_o && !priority_unit_enable_i |-> !int_enable_o)
    else $error("enable left on after interrupt");
  save_zero_a: assert property (mem_we_o && !priority_unit_enable_i |-> mem_addr_o == 15'h0000)
    else $error("return count not saved at zero");
  vec_even_a: assert property (pc_load_o && priority_unit_enable_i && !restore_load_o |->
    !pc_value_o[0] && basic_mode_o)
    else $error("vector odd or mode not basic");
  // Main scenarios reached
  cover property (pc_load_o && !priority_unit_enable_i);
  cover property (pc_load_o && priority_unit_enable_i);
  cover property (break_state_o && other_brk_i);
  cover property (restore_load_o);
endmodule
bind ppi_ctrl ppi_ctrl_chk chk (.*);

// [test/ppi_far.sv]
// Far side model: device flags, processor memory and break grant
`timescale 1ns/1ps
module ppi_far (
  input wire logic clk_i,
  input wire logic [1:0] dev_flag_i,
  input wire logic slow_i,
  input wire logic brk_req_i,
  input wire logic mem_we_i,
  input wire logic mem_re_i,
  input wire logic [14:0] mem_addr_i,
  input wire logic [11:0] mem_wdata_i,
  output logic req_n_o,
  output logic [1:0] skip_o,
  output logic grant_o,
  output logic [11:0] rdata_o
);
  logic [11:0] mem [0:32767];
  logic [1:0] gate_ff = 2'd0;
  logic [11:0] rd_ff = 12'h0a5a;
  // Open collector: any set flag grounds the shared line
  assign req_n_o = ~|dev_flag_i;
  assign skip_o = dev_flag_i;
  // A busy processor withholds the grant one cycle in three; a period of two
  // would lock against the unit's own tick and never grant at all
  assign grant_o = brk_req_i && (!slow_i || gate_ff != 2'd0);
  assign rdata_o = rd_ff;
  // Read data stands one cycle; otherwise it toggles so stale data never matches
  always_ff @(posedge clk_i) begin
    gate_ff <= (gate_ff == 2'd2) ? 2'd0 : gate_ff + 2'd1;
    if (mem_we_i) mem[mem_addr_i] <= mem_wdata_i;
    rd_ff <= mem_re_i ? mem[mem_addr_i] : ~rd_ff;
  end
endmodule

// [test/ppi_ctrl_bench.sv]
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module ppi_ctrl_bench;
  import ppi_pkg::*;
  logic clk_i = 0, rst_i = 1, priority_unit_enable_i = 0, interrupt_on_instruction_i = 0;
  logic interrupt_off_i = 0, restore_i = 0, instr_done_i = 0, alt_mode_i = 0, link_i = 0;
  logic overflow_i = 0, user_flag_i = 0, stack_load_i = 0, other_brk_i = 0, slow = 0;
  logic int_req_n_i, brk_grant_i, brk_req_o, break_state_o, mem_we_o, mem_re_o, pc_load_o;
  logic basic_mode_o, restore_load_o, int_enable_o;
  logic [1:0] flags = 0;
  logic [6:0] lvl_req_i = 0, vec_high_i = 7'h7F;
  logic [27:0] lvl_jumper_i = 28'hFFF_FFFF;
  logic [11:0] accumulator_i = 0, program_counter_i = 0, multiplier_quotient_i = 0, mem_rdata_i;
  logic [11:0] mem_wdata_o, pc_value_o, rest_ac_o, rest_mq_o, rest_status_o, rest_fields_o;
  logic [2:0] instr_field_i = 0, data_field_i = 0, vec_field_i = 0, if_value_o;
  logic [14:0] stack_base_i = 15'h0FFE, sp = 15'h0FFE, mem_addr_o;
  logic [3:0] machine_level_o, cur = 4'hF;
  logic [26:0] w;
  int mismatches = 0, cmp_count = 0, seed = 35, cyc = 0;
  logic [26:0] wr_q[$];
  logic [14:0] pc_q[$], q;
  logic [59:0] fr_stk[$], f;
  ppi_ctrl #(.TGEN_DIV(2)) uut (.*);
  ppi_far far (.clk_i, .dev_flag_i(flags), .slow_i(slow), .brk_req_i(brk_req_o),
    .mem_we_i(mem_we_o), .mem_re_i(mem_re_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .req_n_o(int_req_n_i), .skip_o(), .grant_o(brk_grant_i),
    .rdata_o(mem_rdata_i));
  // ****
  // Clock, timeout and verdict
  // ****
  initial forever #2.5 clk_i = ~clk_i;
  task automatic stop_test;
    if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      stop_test;
    end
  end
  // Other break devices compete only while the processor is slow
  always @(posedge clk_i) other_brk_i <= slow && ($random(seed) % 5 == 0);
  // Writes and PC loads are matched against the oldest expectation, restores against the newest frame
  always @(posedge clk_i) begin
    if (!rst_i && mem_we_o) begin
      w = wr_q.size() ? wr_q.pop_front() : 'x;
      `CHK("write", w, {mem_addr_o, mem_wdata_o})
    end
    if (!rst_i && pc_load_o) begin
      q = pc_q.size() ? pc_q.pop_front() : 'x;
      `CHK("pc", q, {if_value_o, pc_value_o})
    end
    if (!rst_i && restore_load_o) begin
      f = fr_stk.size() ? fr_stk.pop_back() : 'x;
      `CHK("restored ac", f[47:36], rest_ac_o)
      `CHK("restored status", f[35:24], rest_status_o)
      `CHK("restored mq", f[23:12], rest_mq_o)
      `CHK("restored fields", f[11:0], rest_fields_o)
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Boundary strobe once the request synchroniser has settled
  task automatic boundary;
    tick(3);
    instr_done_i <= 1;
    tick(1);
    instr_done_i <= 0;
  endtask
  task automatic settle;
    int n;
    n = 0;
    tick(2);
    while (break_state_o && n < 200) begin
      tick(1);
      n++;
    end
    tick(2);
  endtask
  // Push of input k; a second boundary retires the routine's first instruction
  task automatic push(input int k);
    logic [3:0] l;
    l = lvl_jumper_i[4*k +: 4];
    accumulator_i <= 12'($random(seed));
    multiplier_quotient_i <= 12'($random(seed));
    vec_field_i <= 3'($random(seed));
    {link_i, overflow_i, user_flag_i, instr_field_i, data_field_i} <= 9'($random(seed));
    tick(1);
    // The status word keeps the level that was current before this push
    fr_stk.push_back({program_counter_i, accumulator_i, alt_mode_i, overflow_i, link_i, 5'b0,
      cur, multiplier_quotient_i, 1'b0, user_flag_i, 2'b0, instr_field_i, 2'b0, data_field_i});
    wr_q.push_back({sp, accumulator_i});
    wr_q.push_back({sp + 15'd1, program_counter_i});
    wr_q.push_back({sp + 15'd2, alt_mode_i, overflow_i, link_i, 5'b0, cur});
    wr_q.push_back({sp + 15'd3, multiplier_quotient_i});
    wr_q.push_back({sp + 15'd4, 1'b0, user_flag_i, 2'b0, instr_field_i, 2'b0, data_field_i});
    pc_q.push_back({vec_field_i, vec_high_i, l, 1'b0});
    sp = sp + 15'd5;
    cur = l;
    repeat (2) begin
      boundary;
      settle;
    end
    `CHK("level", l, machine_level_o)
    `CHK("mode", 1'b1, basic_mode_o)
  endtask
  // Pop returns the newest frame: PC and field reload, level and mode restored
  task automatic pop(input logic [3:0] l, input logic m);
    logic [59:0] e;
    e = fr_stk[$];
    pc_q.push_back({e[6:4], e[59:48]});
    restore_i <= 1;
    boundary;
    restore_i <= 0;
    settle;
    `CHK("level", l, machine_level_o)
    `CHK("mode", m, basic_mode_o)
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    tick(2);
    rst_i <= 0;
    tick(2);
    `CHK("level", 4'hF, machine_level_o)
    for (int a = 0; a < 2; a++) begin
      alt_mode_i <= a[0];
      program_counter_i <= 12'($random(seed));
      interrupt_on_instruction_i <= 1;
      tick(1);
      interrupt_on_instruction_i <= 0;
      flags[a] <= 1;
      tick(1);
      `CHK("enable", 1'b1, int_enable_o)
      if (a == 0) wr_q.push_back({15'h0000, program_counter_i});
      pc_q.push_back({3'd0, a ? 12'h021 : 12'h001});
      boundary;
      tick(4);
      `CHK("enable", 1'b0, int_enable_o)
      boundary;
      tick(4);
      flags <= 0;
    end
    alt_mode_i <= 0;
    // Interrupt-off must drop an enable that interrupt-on has just raised
    interrupt_on_instruction_i <= 1;
    tick(1);
    interrupt_on_instruction_i <= 0;
    interrupt_off_i <= 1;
    tick(1);
    interrupt_off_i <= 0;
    tick(1);
    `CHK("enable", 1'b0, int_enable_o)
    priority_unit_enable_i <= 1;
    interrupt_on_instruction_i <= 1;
    stack_load_i <= 1;
    for (int k = 0; k < 7; k++) lvl_jumper_i[4*k +: 4] <= 4'(12 - 2 * k);
    tick(1);
    stack_load_i <= 0;
    interrupt_on_instruction_i <= 0;
    lvl_req_i <= 7'h01;
    push(0);
    slow <= 1;
    alt_mode_i <= 1;
    lvl_req_i <= 7'h43;
    push(6);
    lvl_req_i <= 7'h00;
    pop(4'd12, 1'b0);
    pop(4'hF, 1'b1);
    tick(5);
    `CHK("left over", 0, wr_q.size() + pc_q.size() + fr_stk.size())
    stop_test;
  end
endmodule
